// file: hw/adc_scan_pkg.sv
// constants for the converter trigger and scan control block, whose turbo_active output stays low
// assumes a 100 MHz clock and an apb master with 32-bit data
package adc_scan_pkg;
  localparam logic [11:0] off_ctrl_first = 12'h000;
  localparam logic [11:0] off_ctrl_second = 12'h004;
  localparam logic [11:0] off_scan_low = 12'h008;
  localparam logic [11:0] off_scan_high = 12'h00c;
  localparam logic [11:0] off_core_trig = 12'h010;
  localparam logic [11:0] off_status = 12'h014;
  localparam int turbo_bit = 31;
  localparam int strg_lo = 16;
  localparam int strg_hi = 20;
  localparam int sample_time_count_lo = 16;
  localparam int sample_time_count_hi = 25;
  localparam int eos_bit = 29;
  localparam logic [4:0] trig_level = 5'h02;
  localparam int bad_channel = 26;
  localparam logic [9:0] scan_sample_time_count_extra = 10'h004;
  localparam int conv_cycles = 13;
  localparam logic [31:0] ctrl_first_rst = 32'h0000_0000;
  localparam logic [31:0] ctrl_second_rst = 32'h0000_0000;
  localparam logic [31:0] status_rst = 32'h0000_0000;
  localparam logic [4:0] ilv_min_sample_time_count [2:6] = '{5'h0d, 5'h07, 5'h05,
    5'h04, 5'h03};
endpackage

// file: hw/adc_trigger_scan_control.sv
// trigger and scan list sequencing of the converter, turbo_active held low
// assumes apb master on clk, trigger sources and core done from pins
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module adc_trigger_scan_control #(
  parameter int n_trig = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [n_trig-1:0] trig_in,
  input wire logic debug_mode,
  input wire logic core_done,
  output logic core_start,
  output logic [5:0] core_channel,
  output logic [9:0] core_sample_time_count,
  output logic burst_trigger,
  output logic turbo_active,
  output logic end_of_scan_ready
);
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_issue = 2'b01,
    st_wait = 2'b10
  } scan_e;

  logic [31:0] converter_control_first_r, converter_control_first_nxt;
  logic [31:0] converter_control_second_r, converter_control_second_nxt;
  logic [31:0] scan_select_low_r, scan_select_low_nxt;
  logic [31:0] scan_select_high_r, scan_select_high_nxt;
  logic [4:0] core_trigger_select_r, core_trigger_select_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
  logic [n_trig-1:0] trig_s1_r, trig_s2_r, trig_s3_r;
  logic dbg_s1_r, dbg_s2_r, done_s1_r, done_s2_r;
  scan_e state_r, state_nxt;
  logic [5:0] chan_r, chan_nxt;
  logic start_r, start_nxt, eos_r, eos_nxt, restart_r, restart_nxt;
  logic burst_r, burst_nxt;
  logic [63:0] sel_mask;
  logic scan_trig, lvl_trig;
  logic [5:0] first_ch, next_ch;
  logic found_first, found_next;
  logic [6:0] first_hit, next_hit;

  // lowest selected channel at or above a start index
  function automatic logic [6:0] find_ch(input logic [63:0] m,
    input logic [6:0] from);
    logic [6:0] r;
    r = 7'h40;
    for (int i = 63; i >= 0; i--) begin
      if (m[i] && (7'(i) >= from)) begin
        r = 7'(i);
      end
    end
    return r;
  endfunction

  always_comb begin
    // input 26 masked out
    // bad channel drop
    sel_mask = {scan_select_high_r, scan_select_low_r};
    sel_mask[adc_scan_pkg::bad_channel] = 1'b0;
    scan_trig = trig_s2_r[converter_control_first_r[adc_scan_pkg::strg_hi:
      adc_scan_pkg::strg_lo]] & ~trig_s3_r[converter_control_first_r[
      adc_scan_pkg::strg_hi:adc_scan_pkg::strg_lo]];
    lvl_trig = trig_s2_r[core_trigger_select_r];
    first_hit = find_ch(sel_mask, 7'h00);
    next_hit = find_ch(sel_mask, {1'b0, chan_r} + 7'h01);
    found_first = ~first_hit[6];
    first_ch = first_hit[5:0];
    found_next = ~next_hit[6];
    next_ch = next_hit[5:0];
  end

  always_comb begin
    converter_control_first_nxt = converter_control_first_r;
    converter_control_second_nxt = converter_control_second_r;
    scan_select_low_nxt = scan_select_low_r;
    scan_select_high_nxt = scan_select_high_r;
    core_trigger_select_nxt = core_trigger_select_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    pready_nxt = psel & ~penable;
    if (psel && !penable) begin
      case (paddr)
        adc_scan_pkg::off_ctrl_first: prdata_nxt = converter_control_first_r;
        adc_scan_pkg::off_ctrl_second: prdata_nxt = {
          converter_control_second_r[31:30], eos_r,
          converter_control_second_r[28:0]};
        adc_scan_pkg::off_scan_low: prdata_nxt = scan_select_low_r;
        adc_scan_pkg::off_scan_high: prdata_nxt = scan_select_high_r;
        adc_scan_pkg::off_core_trig: prdata_nxt = {27'h0,
          core_trigger_select_r};
        adc_scan_pkg::off_status: prdata_nxt = {24'h0, 2'h0, chan_r};
        default: begin
          prdata_nxt = 32'h0000_0000;
          pslverr_nxt = 1'b1;
        end
      endcase
      if (pwrite) begin
        case (paddr)
          adc_scan_pkg::off_ctrl_first: converter_control_first_nxt = pwdata;
          adc_scan_pkg::off_ctrl_second:
            converter_control_second_nxt = pwdata;
          adc_scan_pkg::off_scan_low: scan_select_low_nxt = pwdata;
          adc_scan_pkg::off_scan_high: scan_select_high_nxt = pwdata;
          adc_scan_pkg::off_core_trig: core_trigger_select_nxt = pwdata[4:0];
          default: ;
        endcase
      end
    end
  end

  always_comb begin
    state_nxt = state_r;
    chan_nxt = chan_r;
    start_nxt = 1'b0;
    eos_nxt = eos_r;
    restart_nxt = restart_r;
    burst_nxt = lvl_trig && !dbg_s2_r &&
      (core_trigger_select_r == adc_scan_pkg::trig_level);
    // reading the second control word clears the ready flag
    if (pready_r && !pwrite && paddr == adc_scan_pkg::off_ctrl_second) begin
      eos_nxt = 1'b0;
    end
    case (state_r)
      st_idle: begin
        if (scan_trig && found_first) begin
          chan_nxt = first_ch;
          state_nxt = st_issue;
          restart_nxt = 1'b0;
        end
      end
      st_issue: begin
        start_nxt = 1'b1;
        state_nxt = st_wait;
      end
      st_wait: begin
        if (done_s2_r) begin
          if (found_next) begin
            chan_nxt = next_ch;
            state_nxt = st_issue;
          end else begin
            if (!restart_r) begin
              eos_nxt = 1'b1;
            end
            restart_nxt = 1'b0;
            state_nxt = st_idle;
          end
        end
      end
      default: state_nxt = st_idle;
    endcase
    if (scan_trig && state_r != st_idle && found_first) begin
      chan_nxt = first_ch;
      state_nxt = st_issue;
      restart_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      converter_control_first_r <= adc_scan_pkg::ctrl_first_rst;
      converter_control_second_r <= adc_scan_pkg::ctrl_second_rst;
      scan_select_low_r <= 32'h0000_0000;
      scan_select_high_r <= 32'h0000_0000;
      core_trigger_select_r <= 5'h00;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      trig_s1_r <= '0;
      trig_s2_r <= '0;
      trig_s3_r <= '0;
      dbg_s1_r <= 1'b0;
      dbg_s2_r <= 1'b0;
      done_s1_r <= 1'b0;
      done_s2_r <= 1'b0;
      state_r <= st_idle;
      chan_r <= 6'h00;
      start_r <= 1'b0;
      eos_r <= 1'b0;
      restart_r <= 1'b0;
      burst_r <= 1'b0;
    end else begin
      converter_control_first_r <= converter_control_first_nxt;
      converter_control_second_r <= converter_control_second_nxt;
      scan_select_low_r <= scan_select_low_nxt;
      scan_select_high_r <= scan_select_high_nxt;
      core_trigger_select_r <= core_trigger_select_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      trig_s1_r <= trig_in;
      trig_s2_r <= trig_s1_r;
      trig_s3_r <= trig_s2_r;
      dbg_s1_r <= debug_mode;
      dbg_s2_r <= dbg_s1_r;
      done_s1_r <= core_done;
      done_s2_r <= done_s1_r;
      state_r <= state_nxt;
      chan_r <= chan_nxt;
      start_r <= start_nxt;
      eos_r <= eos_nxt;
      restart_r <= restart_nxt;
      burst_r <= burst_nxt;
    end
  end

  // shared-core sample time as programmed, margin is software's job
  // sample time to cores
  logic [9:0] sample_time_count_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_time_count_r <= 10'h000;
      turbo_active <= 1'b0;
    end else begin
      sample_time_count_r <= converter_control_second_r[adc_scan_pkg::sample_time_count_hi:
        adc_scan_pkg::sample_time_count_lo];
      turbo_active <= 1'b0;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign core_start = start_r;
  assign core_channel = chan_r;
  assign core_sample_time_count = sample_time_count_r;
  assign burst_trigger = burst_r;
  assign end_of_scan_ready = eos_r;
endmodule

// file: tb/adc_scan_sva.sv
// assertions on the control block ports
// assumes a bind into every adc_trigger_scan_control
`timescale 1ns/1ps
module adc_scan_sva #(
  parameter int n_trig = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic debug_mode,
  input wire logic core_start,
  input wire logic [5:0] core_channel,
  input wire logic [9:0] core_sample_time_count,
  input wire logic burst_trigger,
  input wire logic turbo_active,
  input wire logic end_of_scan_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_turbo; !turbo_active; endproperty
  a_turbo: assert property (p_turbo) else $error("turbo on");
  property p_chan; core_start |-> core_channel != 6'h1a; endproperty
  a_chan: assert property (p_chan) else $error("bad channel");
  property p_dbg; debug_mode [*4] |-> !burst_trigger; endproperty
  a_dbg: assert property (p_dbg) else $error("burst in debug");
  property p_sample_time_count;
    !$stable(core_sample_time_count) |-> $past(psel && !penable && pwrite, 2);
  endproperty
  a_sample_time_count: assert property (p_sample_time_count) else $error("sample_time_count moved");
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("lone error");
  property p_start; core_start |=> !core_start; endproperty
  a_start: assert property (p_start) else $error("start held");
  property p_eos; $rose(end_of_scan_ready) |-> !core_start; endproperty
  a_eos: assert property (p_eos) else $error("early ready");
  c_eos: cover property ($rose(end_of_scan_ready));
  c_burst: cover property (burst_trigger);
  c_err: cover property (pslverr);
endmodule
bind adc_trigger_scan_control adc_scan_sva #(.n_trig(n_trig)) i_sva (
  .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .debug_mode(debug_mode), .core_start(core_start),
  .core_channel(core_channel), .core_sample_time_count(core_sample_time_count),
  .burst_trigger(burst_trigger), .turbo_active(turbo_active),
  .end_of_scan_ready(end_of_scan_ready));

// file: tb/core_model.sv
// converter core model answering the latest start with a done pulse
// assumes start is a one-cycle pulse from the control block
`timescale 1ns/1ps
module core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic core_start,
  input wire logic slow,
  output logic core_done
);
  logic [3:0] cnt_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_r <= 4'h0;
    else if (core_start) cnt_r <= slow ? 4'hc : 4'h3;
    else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
  end
  assign core_done = (cnt_r == 4'h1);
endmodule

// file: tb/tb.sv
// random and corner tests of the trigger and scan control block
// assumes the core model on the far side of the scan port
`timescale 1ns/1ps
module tb;
  logic clk, rst_n, psel, penable, pwrite, debug_mode, slow, err;
  logic pready, pslverr, core_done, core_start, burst_trigger;
  logic turbo_active, end_of_scan_ready;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, trig_in, rd, sel;
  logic [5:0] core_channel;
  logic [9:0] core_sample_time_count;
  logic [4:0] src;
  int fails, n_tests, n_start, cyc;
  adc_trigger_scan_control i_dut (.*);
  core_model i_core (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  function automatic int n_exp(input logic [31:0] s);
    return $countones(s & ~32'h0400_0000);
  endfunction
  task automatic scan(input logic again);
    n_start = 0;
    trig_in[src] <= 1'b1;
    repeat (2) @(posedge clk);
    trig_in[src] <= 1'b0;
    if (again) begin
      while (n_start == 0) @(posedge clk);
      trig_in[src] <= 1'b1;
      repeat (2) @(posedge clk);
      trig_in[src] <= 1'b0;
    end
    for (int i = 0; i < 2000 && end_of_scan_ready !== 1'b1; i++)
      @(posedge clk);
  endtask
  task automatic finish_test;
    $display("tests %0d fails %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
    if (core_start === 1'b1) begin
      n_start++;
      chk(core_channel !== 6'h1a, 1);
    end
  end
  initial begin
    {psel, penable, pwrite, debug_mode, slow, paddr, pwdata, trig_in} = '0;
    rst_n = 1'b0;
    void'($urandom(32'h6247));
    src = 5'($urandom);
    sel = $urandom | 32'h8400_0001;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    apb(1'b0, 12'h000, 0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h020, 0);
    chk(err, 1'b1);
    chk(rd, 32'h0);
    apb(1'b1, 12'h000, 32'h8000_0000 | (32'(src) << 16));
    chk(turbo_active, 0);
    apb(1'b1, 12'h004, 32'd17 << 16);
    chk(core_sample_time_count, 17);
    apb(1'b1, 12'h00c, 0);
    apb(1'b1, 12'h008, sel);
    slow <= 1'($urandom);
    scan(1'b0);
    chk(n_start, n_exp(sel));
    apb(1'b0, 12'h004, 0);
    chk(rd[29], 1);
    chk(rd[25:16], 10'h011);
    slow <= 1'b1;
    scan(1'b1);
    chk(n_start, n_exp(sel) + 1);
    chk(end_of_scan_ready, 0);
    apb(1'b1, 12'h010, 32'h2);
    trig_in[adc_scan_pkg::trig_level] <= 1'b1;
    repeat (5) @(posedge clk);
    chk(burst_trigger, 1);
    debug_mode <= 1'b1;
    repeat (5) @(posedge clk);
    chk(burst_trigger, 0);
    finish_test();
  end
endmodule
